// [tcoc_top.sv]
/*
  8-bit timer with two compare output channels behind an AXI4-Lite slave.
  Holds control, counter, compare values, status with mask, interrupt.
  Assumes one AXI master on clk; pin direction lives in the port block.
*/
// The placing of the registers and the AXI4-Lite interface to the registers were left to the implementer.
// Behaviour
// - A nonzero output mode routes the channel waveform to its pin; in PWM, 01 does so only on channel A with high bit.
// - Plain modes, channel A: off, toggle, clear, set on match.
// - Plain modes, channel B: same encoding as channel A.
// - Fast PWM A: clear/set on match, opposite at TOP; toggle needs high bit.
// - Fast PWM B: clear/set on match, opposite at TOP; 01 reserved.
// - Phase PWM A: 10 clears upward, sets downward; 11 opposite; toggle needs high bit.
// - Phase PWM B: 10 clears upward, sets downward; 11 opposite; 01 reserved.
// - Compare equal to TOP in PWM with upper bit: act at TOP only.
// - Control A bits 3 and 2 read zero and ignore writes.
// - Waveform mode is high bit from control B plus two low bits.
// - Modes 0 and 2: TOP 0xFF or compare A, immediate update, flag at MAX.
// - Modes 1 and 5: phase PWM, update at TOP, flag at BOTTOM.
// - Modes 3 and 7: fast PWM, update at TOP; flag at MAX or TOP.
// - MAX is fixed at 0xFF.
// - Fast PWM counts up to TOP, then clears next tick.
// - Phase PWM reverses at TOP, holding TOP one tick.
`timescale 1ns/10ps
module tcoc_top (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             chan_a_pin,
  output logic             chan_a_pin_oe,
  output logic             chan_b_pin,
  output logic             chan_b_pin_oe,
  output logic             irq
);
  import tcoc_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0]  ctrl_a_ff, nxt_ctrl_a;
  logic        wave_high_ff, nxt_wave_high;
  logic [7:0]  prescl_ff, nxt_prescl;
  logic [7:0]  pdiv_ff, nxt_pdiv;
  logic [7:0]  count_ff, nxt_count;
  logic        up_ff, nxt_up;
  logic [7:0]  cmp_a_ff, nxt_cmp_a, cmp_a_buf_ff, nxt_cmp_a_buf;
  logic [7:0]  cmp_b_ff, nxt_cmp_b, cmp_b_buf_ff, nxt_cmp_b_buf;
  logic [2:0]  status_ff, nxt_status, mask_ff, nxt_mask, evt;
  logic        irq_ff, nxt_irq;
  logic        aw_ff, nxt_aw, w_ff, nxt_w, bv_ff, nxt_bv, rv_ff, nxt_rv;
  logic [7:0]  awaddr_ff, nxt_awaddr;
  logic [31:0] wdata_ff, nxt_wdata, rdata_ff, nxt_rdata;
  logic [1:0]  bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
  logic        pin_a_ff, pin_b_ff, oe_a_ff, oe_b_ff, awready_ff, wready_ff, arready_ff;

  logic [2:0]  wave_mode;
  tcoc_kind_t  kind;
  logic [7:0]  top;
  tcoc_cnt_t   cnt;
  logic        match_a, match_b, con_a, con_b, wave_a, wave_b;
  logic        do_wr, do_rd;

  // Decode used for both writes and reads
  function automatic logic addr_known(input logic [7:0] a);
    addr_known = (a == OFS_CTRL_A) || (a == OFS_CTRL_B) || (a == OFS_COUNT) ||
                 (a == OFS_CMP_A) || (a == OFS_CMP_B) || (a == OFS_STATUS) ||
                 (a == OFS_MASK) || (a == OFS_PRESCL);
  endfunction : addr_known

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  always_comb begin
    wave_mode = {wave_high_ff, ctrl_a_ff[1:0]};
    if (wave_mode == WM_FAST_FF || wave_mode == WM_FAST_CMPA) begin
      kind = TCOC_KIND_FAST;
    end else if (wave_mode == WM_PC_FF || wave_mode == WM_PC_CMPA) begin
      kind = TCOC_KIND_PHASE;
    end else begin
      kind = TCOC_KIND_PLAIN;
    end
    // Compare A as TOP in WM_CTC and modes 4 to 7; fixed MAX otherwise
    top = (wave_mode == WM_CTC || wave_high_ff) ? cmp_a_ff : COUNT_MAX;
    cnt.tick     = (pdiv_ff == prescl_ff);
    cnt.at_top   = (count_ff == top);
    cnt.count_up = up_ff;
    match_a      = (count_ff == cmp_a_ff);
    match_b      = (count_ff == cmp_b_ff);
  end

  tcoc_chan u_chan_a (
    .clk        (clk),
    .rst_n      (rst_n),
    .kind       (kind),
    .wave_high  (wave_high_ff),
    .is_chan_a  (1'b1),
    .out_mode   (ctrl_a_ff[POS_MODE_A +: 2]),
    .cnt        (cnt),
    .match      (match_a),
    .cmp_is_top (cmp_a_ff == top),
    .connect    (con_a),
    .wave       (wave_a)
  );

  tcoc_chan u_chan_b (
    .clk        (clk),
    .rst_n      (rst_n),
    .kind       (kind),
    .wave_high  (wave_high_ff),
    .is_chan_a  (1'b0),
    .out_mode   (ctrl_a_ff[POS_MODE_B +: 2]),
    .cnt        (cnt),
    .match      (match_b),
    .cmp_is_top (cmp_b_ff == top),
    .connect    (con_b),
    .wave       (wave_b)
  );

  // ----------------------------------------------------------------
  // Counter, buffers, status and bus
  // ----------------------------------------------------------------
  always_comb begin
    nxt_ctrl_a    = ctrl_a_ff;
    nxt_wave_high = wave_high_ff;
    nxt_prescl    = prescl_ff;
    nxt_pdiv      = cnt.tick ? 8'h00 : pdiv_ff + 8'h01;
    nxt_count     = count_ff;
    nxt_up        = up_ff;
    nxt_cmp_a     = cmp_a_ff;
    nxt_cmp_b     = cmp_b_ff;
    nxt_cmp_a_buf = cmp_a_buf_ff;
    nxt_cmp_b_buf = cmp_b_buf_ff;
    nxt_status    = status_ff;
    nxt_mask      = mask_ff;
    nxt_aw        = aw_ff;
    nxt_w         = w_ff;
    nxt_awaddr    = awaddr_ff;
    nxt_wdata     = wdata_ff;
    nxt_bv        = bv_ff;
    nxt_bresp     = bresp_ff;
    nxt_rv        = rv_ff;
    nxt_rdata     = rdata_ff;
    nxt_rresp     = rresp_ff;
    evt           = 3'h0;
    if (cnt.tick) begin
      if (kind == TCOC_KIND_PHASE) begin
        // Hold TOP one tick by turning there, not after
        if (up_ff && cnt.at_top) begin
          nxt_up    = 1'b0;
          nxt_count = count_ff - 8'h01;
        end else if (!up_ff && count_ff == COUNT_BOTTOM) begin
          nxt_up    = 1'b1;
          nxt_count = count_ff + 8'h01;
          evt[STAT_OVF] = 1'b1;
        end else begin
          nxt_count = up_ff ? count_ff + 8'h01 : count_ff - 8'h01;
        end
        if (up_ff && cnt.at_top) begin
          nxt_cmp_a = cmp_a_buf_ff;
          nxt_cmp_b = cmp_b_buf_ff;
        end
      end else begin
        nxt_up    = 1'b1;
        nxt_count = cnt.at_top ? COUNT_BOTTOM : count_ff + 8'h01;
        if (kind == TCOC_KIND_FAST && cnt.at_top) begin
          nxt_cmp_a = cmp_a_buf_ff;
          nxt_cmp_b = cmp_b_buf_ff;
        end
        if (wave_mode == WM_FAST_CMPA ? cnt.at_top : count_ff == COUNT_MAX) begin
          evt[STAT_OVF] = 1'b1;
        end
      end
      if (match_a) evt[STAT_MATCH_A] = 1'b1;
      if (match_b) evt[STAT_MATCH_B] = 1'b1;
    end
    if (kind == TCOC_KIND_PLAIN) begin
      nxt_cmp_a = cmp_a_buf_ff;
      nxt_cmp_b = cmp_b_buf_ff;
    end
    if (s_axi_awvalid && !aw_ff) begin
      nxt_aw     = 1'b1;
      nxt_awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_ff) begin
      nxt_w     = 1'b1;
      nxt_wdata = s_axi_wdata;
    end
    if (do_wr) begin
      nxt_aw    = 1'b0;
      nxt_w     = 1'b0;
      nxt_bv    = 1'b1;
      nxt_bresp = addr_known(awaddr_ff) ? 2'b00 : 2'b10;
      if (awaddr_ff == OFS_CTRL_A) begin
        nxt_ctrl_a = wdata_ff[7:0] & CTRL_A_WMASK;
      end else if (awaddr_ff == OFS_CTRL_B) begin
        nxt_wave_high = wdata_ff[POS_WAVE_HIGH];
      end else if (awaddr_ff == OFS_COUNT) begin
        nxt_count = wdata_ff[7:0];
      end else if (awaddr_ff == OFS_CMP_A) begin
        nxt_cmp_a_buf = wdata_ff[7:0];
      end else if (awaddr_ff == OFS_CMP_B) begin
        nxt_cmp_b_buf = wdata_ff[7:0];
      end else if (awaddr_ff == OFS_MASK) begin
        nxt_mask = wdata_ff[2:0];
      end else if (awaddr_ff == OFS_PRESCL) begin
        nxt_prescl = wdata_ff[7:0];
      end
    end
    if (bv_ff && s_axi_bready) nxt_bv = 1'b0;
    if (do_rd) begin
      nxt_rv    = 1'b1;
      nxt_rresp = addr_known(s_axi_araddr) ? 2'b00 : 2'b10;
      nxt_rdata = 32'h0000_0000;
      if (s_axi_araddr == OFS_CTRL_A) begin
        nxt_rdata[7:0] = ctrl_a_ff;
      end else if (s_axi_araddr == OFS_CTRL_B) begin
        nxt_rdata[POS_WAVE_HIGH] = wave_high_ff;
      end else if (s_axi_araddr == OFS_COUNT) begin
        nxt_rdata[7:0] = count_ff;
      end else if (s_axi_araddr == OFS_CMP_A) begin
        nxt_rdata[7:0] = cmp_a_buf_ff;
      end else if (s_axi_araddr == OFS_CMP_B) begin
        nxt_rdata[7:0] = cmp_b_buf_ff;
      end else if (s_axi_araddr == OFS_STATUS) begin
        nxt_rdata[2:0] = status_ff;
        // Read clears; events of this cycle are added back below
        nxt_status = 3'h0;
      end else if (s_axi_araddr == OFS_MASK) begin
        nxt_rdata[2:0] = mask_ff;
      end else if (s_axi_araddr == OFS_PRESCL) begin
        nxt_rdata[7:0] = prescl_ff;
      end
    end
    if (rv_ff && s_axi_rready) nxt_rv = 1'b0;
    nxt_status = nxt_status | evt;
    nxt_irq = |(nxt_status & nxt_mask);
  end

  assign do_wr = aw_ff && w_ff && !bv_ff;
  assign do_rd = s_axi_arvalid && !rv_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_a_ff    <= CTRL_A_RST;
      wave_high_ff <= 1'b0;
      prescl_ff    <= PRESCL_RST;
      pdiv_ff      <= 8'h00;
      count_ff     <= COUNT_RST;
      up_ff        <= 1'b1;
      cmp_a_ff     <= CMP_RST;
      cmp_b_ff     <= CMP_RST;
      cmp_a_buf_ff <= CMP_RST;
      cmp_b_buf_ff <= CMP_RST;
      status_ff    <= 3'h0;
      mask_ff      <= 3'h0;
      irq_ff       <= 1'b0;
      aw_ff        <= 1'b0;
      w_ff         <= 1'b0;
      awaddr_ff    <= 8'h00;
      wdata_ff     <= 32'h0000_0000;
      bv_ff        <= 1'b0;
      bresp_ff     <= 2'b00;
      rv_ff        <= 1'b0;
      rdata_ff     <= 32'h0000_0000;
      rresp_ff     <= 2'b00;
      pin_a_ff     <= 1'b0;
      pin_b_ff     <= 1'b0;
      oe_a_ff      <= 1'b0;
      oe_b_ff      <= 1'b0;
      awready_ff   <= 1'b1;
      wready_ff    <= 1'b1;
      arready_ff   <= 1'b1;
    end else begin
      ctrl_a_ff    <= nxt_ctrl_a;
      wave_high_ff <= nxt_wave_high;
      prescl_ff    <= nxt_prescl;
      pdiv_ff      <= nxt_pdiv;
      count_ff     <= nxt_count;
      up_ff        <= nxt_up;
      cmp_a_ff     <= nxt_cmp_a;
      cmp_b_ff     <= nxt_cmp_b;
      cmp_a_buf_ff <= nxt_cmp_a_buf;
      cmp_b_buf_ff <= nxt_cmp_b_buf;
      status_ff    <= nxt_status;
      mask_ff      <= nxt_mask;
      irq_ff       <= nxt_irq;
      aw_ff        <= nxt_aw;
      w_ff         <= nxt_w;
      awaddr_ff    <= nxt_awaddr;
      wdata_ff     <= nxt_wdata;
      bv_ff        <= nxt_bv;
      bresp_ff     <= nxt_bresp;
      rv_ff        <= nxt_rv;
      rdata_ff     <= nxt_rdata;
      rresp_ff     <= nxt_rresp;
      pin_a_ff     <= wave_a;
      pin_b_ff     <= wave_b;
      oe_a_ff      <= con_a;
      oe_b_ff      <= con_b;
      awready_ff   <= !nxt_aw;
      wready_ff    <= !nxt_w;
      arready_ff   <= !nxt_rv;
    end
  end

  // Ready is a registered "slot empty" flag so it comes from a flop
  assign s_axi_awready = awready_ff;
  assign s_axi_wready  = wready_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_bvalid  = bv_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_rvalid  = rv_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;
  assign chan_a_pin    = pin_a_ff;
  assign chan_a_pin_oe = oe_a_ff;
  assign chan_b_pin    = pin_b_ff;
  assign chan_b_pin_oe = oe_b_ff;
  assign irq           = irq_ff;

endmodule : tcoc_top

// [tcoc_pkg.sv]
/*
  Package for the 8-bit timer compare output block: register map, field
  positions, reset values, waveform mode codes and shared types.
  Assumes a 32-bit AXI4-Lite register bus with one register per word.
*/
package tcoc_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL_A  = 8'h00;
  localparam logic [7:0] OFS_CTRL_B  = 8'h04;
  localparam logic [7:0] OFS_COUNT   = 8'h08;
  localparam logic [7:0] OFS_CMP_A   = 8'h0c;
  localparam logic [7:0] OFS_CMP_B   = 8'h10;
  localparam logic [7:0] OFS_STATUS  = 8'h14;
  localparam logic [7:0] OFS_MASK    = 8'h18;
  localparam logic [7:0] OFS_PRESCL  = 8'h1c;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int         POS_MODE_A     = 6;
  localparam int         POS_MODE_B     = 4;
  localparam int         POS_WAVE_HIGH  = 3;
  localparam logic [7:0] CTRL_A_WMASK   = 8'hf3;
  localparam logic [7:0] CTRL_A_RST     = 8'h00;
  localparam logic [7:0] CTRL_B_RST     = 8'h00;
  localparam logic [7:0] COUNT_RST      = 8'h00;
  localparam logic [7:0] CMP_RST        = 8'h00;
  localparam logic [7:0] PRESCL_RST     = 8'h00;
  localparam logic [7:0] COUNT_MAX      = 8'hff;
  localparam logic [7:0] COUNT_BOTTOM   = 8'h00;
  localparam int         STAT_OVF       = 0;
  localparam int         STAT_MATCH_A   = 1;
  localparam int         STAT_MATCH_B   = 2;

  // ----------------------------------------------------------------
  // Waveform modes and output modes
  // ----------------------------------------------------------------
  localparam logic [2:0] WM_NORMAL     = 3'h0;
  localparam logic [2:0] WM_PC_FF      = 3'h1;
  localparam logic [2:0] WM_CTC        = 3'h2;
  localparam logic [2:0] WM_FAST_FF    = 3'h3;
  localparam logic [2:0] WM_PC_CMPA    = 3'h5;
  localparam logic [2:0] WM_FAST_CMPA  = 3'h7;
  localparam logic [1:0] OM_OFF        = 2'h0;
  localparam logic [1:0] OM_TOGGLE     = 2'h1;
  localparam logic [1:0] OM_CLEAR      = 2'h2;
  localparam logic [1:0] OM_SET        = 2'h3;

  typedef enum logic [2:0] {
    TCOC_KIND_PLAIN = 3'b001,
    TCOC_KIND_FAST  = 3'b010,
    TCOC_KIND_PHASE = 3'b100
  } tcoc_kind_t;

  // Counter events shared with each channel
  typedef struct packed {
    logic tick;
    logic at_top;
    logic count_up;
  } tcoc_cnt_t;

endpackage : tcoc_pkg

// [tcoc_chan.sv]
/*
  One compare output channel: decides the pin action per compare match,
  TOP and direction, and holds the waveform flip-flop.
  Assumes tick, top and match strobes come from the same clock.
*/
`timescale 1ns/10ps
module tcoc_chan (
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire tcoc_pkg::tcoc_kind_t  kind,
  input  wire logic                  wave_high,
  input  wire logic                  is_chan_a,
  input  wire logic [1:0]            out_mode,
  input  wire tcoc_pkg::tcoc_cnt_t   cnt,
  input  wire logic                  match,
  input  wire logic                  cmp_is_top,
  output logic                       connect,
  output logic                       wave
);
  import tcoc_pkg::*;

  logic wave_ff;
  logic nxt_wave;
  logic hit;

  // ----------------------------------------------------------------
  // Pin action
  // ----------------------------------------------------------------
  always_comb begin
    nxt_wave = wave_ff;
    connect  = (out_mode != OM_OFF);
    // Toggle in PWM exists only on channel A with the high mode bit
    if (kind != TCOC_KIND_PLAIN && out_mode == OM_TOGGLE && !(is_chan_a && wave_high)) begin
      connect = 1'b0;
    end
    // Match on TOP is ignored for PWM set/clear; TOP action alone applies
    hit = match && !(kind != TCOC_KIND_PLAIN && out_mode[1] && cmp_is_top);
    if (cnt.tick && connect) begin
      case (kind)
        TCOC_KIND_PLAIN: begin
          if (hit) begin
            case (out_mode)
              OM_TOGGLE: nxt_wave = !wave_ff;
              OM_CLEAR:  nxt_wave = 1'b0;
              OM_SET:    nxt_wave = 1'b1;
              default:   nxt_wave = wave_ff;
            endcase
          end
        end
        TCOC_KIND_FAST: begin
          if (out_mode == OM_TOGGLE) begin
            if (hit) nxt_wave = !wave_ff;
          end else if (cnt.at_top) begin
            nxt_wave = (out_mode == OM_CLEAR);
          end else if (hit) begin
            nxt_wave = (out_mode == OM_SET);
          end
        end
        TCOC_KIND_PHASE: begin
          if (out_mode == OM_TOGGLE) begin
            if (hit) nxt_wave = !wave_ff;
          end else if (out_mode[1] && cmp_is_top && cnt.at_top) begin
            nxt_wave = (out_mode == OM_CLEAR);
          end else if (hit) begin
            nxt_wave = (out_mode == OM_SET) ~^ cnt.count_up;
          end
        end
        default: nxt_wave = wave_ff;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wave_ff <= 1'b0;
    end else begin
      wave_ff <= nxt_wave;
    end
  end

  assign wave = wave_ff;

endmodule : tcoc_chan

// [tcoc_properties.sv]
/*
  Concurrent checks on the timer block's bus and pin enable ports.
  Assumes one clock domain and the register map of tcoc_pkg.
*/
`timescale 1ns/10ps
module tcoc_properties
  import tcoc_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        chan_a_pin_oe,
  input wire logic        chan_b_pin_oe
);
  // ------------------------------
  // Bus and pin enable checks
  // ------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  logic bad_wr;
  logic bad_rd;
  // Past the last register or off a word boundary
  assign bad_wr = s_axi_awaddr > OFS_PRESCL || s_axi_awaddr[1:0] != 2'h0;
  assign bad_rd = s_axi_araddr > OFS_PRESCL || s_axi_araddr[1:0] != 2'h0;
  sequence wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence ctrl_wr;
    wr_take ##0 s_axi_awaddr == OFS_CTRL_A;
  endsequence
  write_answer_a: assert property (wr_take |-> ##1 !s_axi_awready ##1 s_axi_bvalid)
    else $error("write answer not on time");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
  read_answer_a: assert property (rd_take |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer not on time");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
  wr_refused_a: assert property (wr_take ##0 bad_wr |-> ##2 s_axi_bresp == 2'h2)
    else $error("unmapped write accepted");
  rd_refused_a: assert property (rd_take ##0 bad_rd
    |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0) else $error("unmapped read accepted");
  ctrl_zero_a: assert property (
    rd_take ##0 s_axi_araddr == OFS_CTRL_A |=> s_axi_rdata[3:2] == 2'h0)
    else $error("reserved control bits not zero");
  conn_a_a: assert property (
    ctrl_wr ##0 s_axi_wdata[7:6] != 2'h0 |-> ##[2:4] chan_a_pin_oe)
    else $error("channel a pin not connected");
  conn_b_a: assert property (
    ctrl_wr ##0 s_axi_wdata[5:4] != 2'h0 |-> ##[2:4] chan_b_pin_oe)
    else $error("channel b pin not connected");
endmodule : tcoc_properties

bind tcoc_top tcoc_properties tcoc_properties_i (
  .clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
  .s_axi_rvalid, .s_axi_rready, .chan_a_pin_oe, .chan_b_pin_oe
);

// [tcoc_load.sv]
/*
  External load on one compare pin: counts clocks with the wire high.
  Assumes a pull-down holds the wire low while the driver is off.
*/
`timescale 1ns/10ps
module tcoc_load (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        pin,
  input  wire logic        oe,
  output logic             level,
  output logic [15:0]      high_count
);
  // ------------------------------
  // Wire level and high time
  // ------------------------------
  logic [15:0] nxt_high_count;
  // Pull-down wins while the driver is off
  assign level = oe ? pin : 1'b0;
  always_comb begin
    nxt_high_count = high_count + 16'(level);
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      high_count <= 16'h0;
    end else begin
      high_count <= nxt_high_count;
    end
  end
endmodule : tcoc_load

// [tcoc_tb_top.sv]
/*
  Testbench for the timer compare output block: bus master tasks, two pin
  loads, one task per scenario. Assumes the map and codes of tcoc_pkg.
*/
`timescale 1ns/10ps
module tcoc_tb_top;
  import tcoc_pkg::*;
  // ------------------------------
  // Signals and instances
  // ------------------------------
  logic        clk = 1'b0, rst_n = 1'b0;
  logic [7:0]  awaddr = 8'h0, araddr = 8'h0;
  logic [31:0] wdata = 32'h0, rdata;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, irq;
  logic        pin_a, pin_b, oe_a, oe_b, lvl_a, lvl_b;
  logic [1:0]  bresp, rresp;
  logic [15:0] hi_a, hi_b;
  int          fail_count = 0, compares = 0;
  tcoc_top tcoc_top_i (.clk(clk), .rst_n(rst_n), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .chan_a_pin(pin_a), .chan_a_pin_oe(oe_a),
    .chan_b_pin(pin_b), .chan_b_pin_oe(oe_b), .irq(irq));
  tcoc_load tcoc_load_a_i (.clk(clk), .rst_n(rst_n), .pin(pin_a), .oe(oe_a),
    .level(lvl_a), .high_count(hi_a));
  tcoc_load tcoc_load_b_i (.clk(clk), .rst_n(rst_n), .pin(pin_b), .oe(oe_b),
    .level(lvl_b), .high_count(hi_b));
  initial forever #50 clk = ~clk;
  // ------------------------------
  // Bus tasks and compares
  // ------------------------------
  // Ready is looked at mid-cycle: it cannot move before the next rising edge
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_hit, w_hit, done;
    done = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!done) begin
      @(negedge clk);
      aw_hit = awvalid && awready;
      w_hit = wvalid && wready;
      done = bvalid && bready;
      r = bresp;
      @(posedge clk);
      if (aw_hit) awvalid <= 1'b0;
      if (w_hit) wvalid <= 1'b0;
    end
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar_hit, done;
    done = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done) begin
      @(negedge clk);
      ar_hit = arvalid && arready;
      done = rvalid && rready;
      d = rdata;
      r = rresp;
      @(posedge clk);
      if (ar_hit) arvalid <= 1'b0;
    end
  endtask : axi_rd
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic near(input string nm, input int exp, input int got);
    chk(nm, 32'h1, 32'(got >= exp - 8 && got <= exp + 8));
  endtask : near
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_wr(a, d, r);
    chk("bresp", 32'h0, 32'(r));
  endtask : wr
  task automatic duty(input int n, output int a, output int b);
    logic [15:0] a0, b0;
    a0 = hi_a;
    b0 = hi_b;
    repeat (n) @(posedge clk);
    a = int'(16'(hi_a - a0));
    b = int'(16'(hi_b - b0));
  endtask : duty
  task automatic look(input logic ea, eb, input logic [1:0] eo, input logic iq);
    @(negedge clk);
    chk("pin a", 32'(ea), 32'(lvl_a));
    chk("pin b", 32'(eb), 32'(lvl_b));
    chk("pin enables", 32'(eo), 32'({oe_a, oe_b}));
    chk("irq", 32'(iq), 32'(irq));
    @(posedge clk);
  endtask : look
  // ------------------------------
  // Scenarios
  // ------------------------------
  task automatic t_regs();
    logic [31:0] d;
    logic [1:0]  r;
    axi_rd(OFS_CTRL_A, d, r);
    chk("ctrl a reset", 32'(CTRL_A_RST), d);
    wr(OFS_CTRL_A, 32'h0d);
    axi_rd(OFS_CTRL_A, d, r);
    chk("ctrl a reserved", 32'h01, d);
    axi_wr(8'h20, 32'h1, r);
    chk("unmapped bresp", 32'h2, 32'(r));
    axi_rd(8'h22, d, r);
    chk("unmapped rresp", 32'h2, 32'(r));
    chk("unmapped rdata", 32'h0, d);
  endtask : t_regs
  task automatic t_plain();
    logic [31:0] d;
    logic [1:0]  r;
    wr(OFS_PRESCL, 32'h0);
    wr(OFS_CMP_A, 32'h80);
    wr(OFS_CMP_B, 32'h40);
    wr(OFS_COUNT, 32'h0);
    wr(OFS_CTRL_A, {24'h0, OM_TOGGLE, OM_SET, 4'h0});
    repeat (200) @(posedge clk);
    look(1'b1, 1'b1, 2'h3, 1'b0);
    wr(OFS_MASK, 32'h1);
    wr(OFS_CTRL_A, {24'h0, OM_SET, OM_CLEAR, 4'h0});
    repeat (250) @(posedge clk);
    look(1'b1, 1'b0, 2'h3, 1'b1);
    axi_rd(OFS_STATUS, d, r);
    chk("status", 32'h7, d);
    repeat (2) @(posedge clk);
    look(1'b1, 1'b0, 2'h3, 1'b0);
    wr(OFS_CTRL_A, {24'h0, OM_CLEAR, OM_TOGGLE, 4'h0});
    repeat (250) @(posedge clk);
    look(1'b0, 1'b1, 2'h3, 1'b1);
    wr(OFS_CTRL_A, 32'h0);
    repeat (3) @(posedge clk);
    look(1'b0, 1'b0, 2'h0, 1'b1);
  endtask : t_plain
  task automatic t_fast();
    int a, b;
    wr(OFS_CTRL_A, {24'h0, OM_CLEAR, OM_SET, 4'h3});
    wr(OFS_CMP_A, 32'h40);
    wr(OFS_CMP_B, 32'h40);
    repeat (300) @(posedge clk);
    duty(512, a, b);
    near("fast a", 130, a);
    near("fast b", 382, b);
    wr(OFS_CTRL_B, 32'h8);
    wr(OFS_CTRL_A, {24'h0, OM_TOGGLE, OM_CLEAR, 4'h3});
    wr(OFS_CMP_A, 32'h3f);
    wr(OFS_CMP_B, 32'h10);
    repeat (300) @(posedge clk);
    duty(512, a, b);
    near("fast toggle a", 256, a);
    near("fast top b", 136, b);
    wr(OFS_CMP_B, 32'h3f);
    repeat (200) @(posedge clk);
    duty(512, a, b);
    near("top match b", 512, b);
  endtask : t_fast
  task automatic t_phase();
    int a, b;
    wr(OFS_CTRL_B, 32'h0);
    wr(OFS_CTRL_A, {24'h0, OM_CLEAR, OM_SET, 4'h1});
    wr(OFS_CMP_A, 32'h40);
    wr(OFS_CMP_B, 32'h40);
    repeat (600) @(posedge clk);
    duty(1020, a, b);
    near("phase a", 256, a);
    near("phase b", 764, b);
    wr(OFS_CTRL_B, 32'h8);
    wr(OFS_CTRL_A, {24'h0, OM_TOGGLE, OM_CLEAR, 4'h1});
    wr(OFS_CMP_A, 32'h3f);
    wr(OFS_CMP_B, 32'h10);
    repeat (600) @(posedge clk);
    duty(1008, a, b);
    near("phase toggle a", 504, a);
    near("phase top b", 256, b);
  endtask : t_phase
  task automatic final_report();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : final_report
  // Waveform modes 4 and 6 are never selected
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_regs();
    t_plain();
    t_fast();
    t_phase();
    final_report();
  end
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    final_report();
  end
endmodule : tcoc_tb_top
